// [rtl/fpc_defines.svh]
`ifndef FPC_DEFINES_SVH
`define FPC_DEFINES_SVH

`define FPC_OP_SANITY 4'h0
`define FPC_OP_READ_DATA 4'h1
`define FPC_OP_READ_CODE 4'h2
`define FPC_OP_RESERVED 4'h3
`define FPC_OP_PROG_EE_ROW 4'h4
`define FPC_OP_PROG_CODE_ROW 4'h5
`define FPC_OP_PROG_CONFIG 4'h6
`define FPC_OP_BULK_ERASE 4'h7
`define FPC_OP_ERASE_EE_ROWS 4'h8
`define FPC_OP_ERASE_CODE_ROWS 4'h9
`define FPC_OP_BLANK_QUERY 4'ha
`define FPC_OP_VERSION 4'hb

`define FPC_LEN_SANITY 8'h01
`define FPC_LEN_READ 8'h04
`define FPC_LEN_PROG_EE_ROW 8'h13
`define FPC_LEN_PROG_CODE_ROW 8'h33
`define FPC_LEN_PROG_CONFIG 8'h04
`define FPC_LEN_BULK_ERASE 8'h02
`define FPC_LEN_ERASE_ROWS 8'h03
`define FPC_LEN_BLANK_QUERY 8'h03
`define FPC_LEN_VERSION 8'h01
`define FPC_CMD_DEPTH 51

`define FPC_RESP_ACK 4'h1
`define FPC_RESP_NACK 4'h2
`define FPC_RESP_LEN 16'h0002

`define FPC_CODE_ROW_WORDS 6'h20
`define FPC_EE_ROW_WORDS 6'h10
`define FPC_CFG_LO 24'hf80000
`define FPC_CFG_HI 24'hf8000c
`define FPC_UID_LO 24'h8005c0
`define FPC_UID_HI 24'h8005ff

`define FPC_CLK_MHZ 40
`define FPC_T_READY_US 15
`define FPC_READY_CYC (`FPC_T_READY_US * `FPC_CLK_MHZ)
`define FPC_T_1MS_US 1000
`define FPC_T_5MS_US 5000
`define FPC_T_300MS_US 300000
`define FPC_1MS_CYC (`FPC_T_1MS_US * `FPC_CLK_MHZ)
`define FPC_5MS_CYC (`FPC_T_5MS_US * `FPC_CLK_MHZ)
`define FPC_300MS_CYC (`FPC_T_300MS_US * `FPC_CLK_MHZ)

`endif

// [rtl/fpc_pkg.sv]
package fpc_pkg;
   typedef enum logic [2:0] {S_IDLE, S_RECV, S_CHECK, S_BUSY, S_READY, S_SEND} fpc_state_t;

   typedef struct packed {
      logic [3:0] opcode;
      logic [7:0] length;
      logic [23:0] addr;
      logic [5:0] row_words;
      logic keep_unit_id;
      logic clear_unit_id;
   } fpc_op_t;

   typedef struct packed {
      logic valid;
      logic is_code;
      logic [23:0] word;
   } fpc_csum_in_t;

   typedef struct packed {
      logic [2:0] clk_s;
      logic [2:0] dat_s;
      logic clk_f;
      logic dat_f;
      logic [15:0] rx_sh;
      logic [3:0] rx_cnt;
      logic rx_valid;
      logic [15:0] tx_sh;
      logic [4:0] tx_cnt;
      logic tx_done;
   } fpc_link_t;

   typedef struct packed {
      fpc_state_t st;
      logic [7:0] idx;
      logic [7:0] len;
      logic [3:0] opcode;
      logic [50:0][15:0] cmd;
      logic ok;
      logic [23:0] timer;
      logic [9:0] pulse;
      logic word_sel;
      logic op_start;
      fpc_op_t op;
      logic [15:0] rd_word;
      logic [15:0] csum;
   } fpc_core_t;
endpackage

// [rtl/fpc_link.sv]
`timescale 1ns/1ps
`include "fpc_defines.svh"

module fpc_link import fpc_pkg::*; (
   input wire logic clk,
   input wire logic rst,
   input wire logic prog_serial_clock_pin,
   input wire logic pgd_in,
   input wire logic rx_en,
   input wire logic tx_load,
   input wire logic [15:0] tx_word,
   output logic rx_valid,
   output logic [15:0] rx_word,
   output logic tx_bit,
   output logic tx_done
);
   fpc_link_t q;
   fpc_link_t next_q;
   logic rise;
   logic fall;

   // a level counts only once the second and third stages agree
   always_comb begin
      next_q = q;
      next_q.clk_s = {q.clk_s[1:0], prog_serial_clock_pin};
      next_q.dat_s = {q.dat_s[1:0], pgd_in};
      rise = 1'b0;
      fall = 1'b0;
      if (q.clk_s[1] == q.clk_s[2]) begin
         next_q.clk_f = q.clk_s[2];
         rise = q.clk_s[2] & ~q.clk_f;
         fall = ~q.clk_s[2] & q.clk_f;
      end
      if (q.dat_s[1] == q.dat_s[2]) begin
         next_q.dat_f = q.dat_s[2];
      end
      next_q.rx_valid = 1'b0;
      next_q.tx_done = 1'b0;
      if (!rx_en) begin
         next_q.rx_cnt = 4'h0;
      end else if (rise) begin
         next_q.rx_sh = {q.rx_sh[14:0], q.dat_f};
         next_q.rx_cnt = q.rx_cnt + 4'h1;
         next_q.rx_valid = (q.rx_cnt == 4'hf);
      end
      if (tx_load) begin
         next_q.tx_sh = tx_word;
         next_q.tx_cnt = 5'h0;
      end else if (fall && q.tx_cnt != 5'h10) begin
         next_q.tx_sh = {q.tx_sh[14:0], 1'b0};
         next_q.tx_cnt = q.tx_cnt + 5'h1;
         next_q.tx_done = (q.tx_cnt == 5'hf);
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         q <= '0;
         q.tx_cnt <= 5'h10;
      end else begin
         q <= next_q;
      end
   end

   assign rx_valid = q.rx_valid;
   assign rx_word = q.rx_sh;
   assign tx_bit = q.tx_sh[15];
   assign tx_done = q.tx_done;

   msb_first_a: assert property (@(posedge clk) disable iff (rst)
      fall && !tx_load && q.tx_cnt < 5'h10 |=> tx_bit == $past(q.tx_sh[14]))
      else $error("transmit shift not msb first");
endmodule // fpc_link

// [rtl/fpc_core.sv]
// What this block does
// - programmer initiates; one response per command
// - drive on falling edge, sample rising
// - sixteen-bit words, most significant bit first
// - after command, executive holds data high
// - data low fifteen microseconds means response ready
// - sanity and version commands, one millisecond
// - four-word data read, one millisecond timeout
// - four-word code read, one millisecond timeout
// - reserved opcode answers negative acknowledge
// - nineteen-word eeprom row program, five milliseconds
// - fifty-one-word code row program, five milliseconds
// - four-word configuration write, five milliseconds
// - two-word bulk or segment erase
// - three-word row erases, eeprom or code
// - three-word blank query, three hundred milliseconds
// - code row 32 words, eeprom 16
// - code row program answers 0x1500, 0x0002
// - configuration write only to configuration addresses
// - checksum adds bytes by native width
// - bulk erase keeps unit id; code row erase of the unit id row clears
`timescale 1ns/1ps
`include "fpc_defines.svh"

module fpc_core import fpc_pkg::*; #(
   parameter logic [23:0] T_1MS_CYC = 24'(`FPC_1MS_CYC),
   parameter logic [23:0] T_5MS_CYC = 24'(`FPC_5MS_CYC),
   parameter logic [23:0] T_300MS_CYC = 24'(`FPC_300MS_CYC)
) (
   input wire logic CLK,
   input wire logic RST,
   input wire logic PROG_SERIAL_CLOCK_PIN,
   input wire logic PROG_SERIAL_DATA_PIN_IN,
   output logic PROG_SERIAL_DATA_PIN_OUT,
   output logic PROG_SERIAL_DATA_PIN_OE_N,
   output logic OP_START,
   output fpc_op_t OP,
   input wire logic OP_DONE,
   input wire logic OP_DONE_OK,
   input wire logic [5:0] DATA_INDEX,
   output logic [15:0] DATA_WORD,
   input wire fpc_csum_in_t CSUM_IN,
   output logic [15:0] CHECKSUM
);
   localparam logic [9:0] READY_LAST = 10'(`FPC_READY_CYC - 1);

   fpc_core_t q;
   fpc_core_t next_q;
   logic rx_valid;
   logic [15:0] rx_word;
   logic tx_bit;
   logic tx_done;
   logic tx_load;
   logic [15:0] tx_word;
   logic [15:0] resp0;
   logic [23:0] addr;
   logic cmd_ok;

   // expected command length; zero marks an opcode that is not served
   function automatic logic [7:0] cmd_len(input logic [3:0] op);
      unique case (op)
         `FPC_OP_SANITY: cmd_len = `FPC_LEN_SANITY;
         `FPC_OP_VERSION: cmd_len = `FPC_LEN_VERSION;
         `FPC_OP_READ_DATA: cmd_len = `FPC_LEN_READ;
         `FPC_OP_READ_CODE: cmd_len = `FPC_LEN_READ;
         `FPC_OP_PROG_EE_ROW: cmd_len = `FPC_LEN_PROG_EE_ROW;
         `FPC_OP_PROG_CODE_ROW: cmd_len = `FPC_LEN_PROG_CODE_ROW;
         `FPC_OP_PROG_CONFIG: cmd_len = `FPC_LEN_PROG_CONFIG;
         `FPC_OP_BULK_ERASE: cmd_len = `FPC_LEN_BULK_ERASE;
         `FPC_OP_ERASE_EE_ROWS: cmd_len = `FPC_LEN_ERASE_ROWS;
         `FPC_OP_ERASE_CODE_ROWS: cmd_len = `FPC_LEN_ERASE_ROWS;
         `FPC_OP_BLANK_QUERY: cmd_len = `FPC_LEN_BLANK_QUERY;
         default: cmd_len = 8'h00;
      endcase
   endfunction

   function automatic logic [23:0] limit(input logic [3:0] op);
      unique case (op)
         `FPC_OP_SANITY, `FPC_OP_VERSION, `FPC_OP_READ_DATA,
         `FPC_OP_READ_CODE: limit = T_1MS_CYC;
         `FPC_OP_BLANK_QUERY: limit = T_300MS_CYC;
         default: limit = T_5MS_CYC;
      endcase
   endfunction

   fpc_link u_link (
      .clk(CLK),
      .rst(RST),
      .prog_serial_clock_pin(PROG_SERIAL_CLOCK_PIN),
      .pgd_in(PROG_SERIAL_DATA_PIN_IN),
      .rx_en(q.st == S_IDLE || q.st == S_RECV),
      .tx_load(tx_load),
      .tx_word(tx_word),
      .rx_valid(rx_valid),
      .rx_word(rx_word),
      .tx_bit(tx_bit),
      .tx_done(tx_done)
   );

   assign addr = {q.cmd[1][7:0], q.cmd[2]};
   assign resp0 = {q.ok ? `FPC_RESP_ACK : `FPC_RESP_NACK, q.opcode, 8'h00};
   assign cmd_ok = cmd_len(q.opcode) != 8'h00 && q.len == cmd_len(q.opcode)
      && (q.opcode != `FPC_OP_PROG_CONFIG
      || (addr >= `FPC_CFG_LO && addr <= `FPC_CFG_HI));
   assign tx_load = (q.st == S_READY && q.pulse == READY_LAST)
      || (q.st == S_SEND && tx_done && !q.word_sel);
   assign tx_word = (q.st == S_SEND) ? `FPC_RESP_LEN : resp0;

   always_comb begin
      next_q = q;
      next_q.op_start = 1'b0;
      next_q.rd_word = (DATA_INDEX < 6'(`FPC_CMD_DEPTH)) ? q.cmd[DATA_INDEX] : 16'h0000;
      if (CSUM_IN.valid) begin
         next_q.csum = q.csum + 16'(CSUM_IN.word[15:8]) + 16'(CSUM_IN.word[7:0])
            + (CSUM_IN.is_code ? 16'(CSUM_IN.word[23:16]) : 16'h0000);
      end
      unique case (q.st)
         S_IDLE: begin
            if (rx_valid) begin
               next_q.cmd[0] = rx_word;
               next_q.opcode = rx_word[15:12];
               next_q.len = rx_word[7:0];
               next_q.idx = 8'h01;
               next_q.st = (rx_word[7:0] <= 8'h01) ? S_CHECK : S_RECV;
            end
         end
         S_RECV: begin
            if (rx_valid) begin
               // words past the buffer are counted but dropped; the length check nacks them
               if (q.idx < 8'(`FPC_CMD_DEPTH)) begin
                  next_q.cmd[q.idx[5:0]] = rx_word;
               end
               next_q.idx = q.idx + 8'h01;
               if (q.idx + 8'h01 == q.len) begin
                  next_q.st = S_CHECK;
               end
            end
         end
         S_CHECK: begin
            next_q.ok = cmd_ok;
            next_q.op_start = cmd_ok;
            next_q.timer = 24'h000000;
            next_q.op.opcode = q.opcode;
            next_q.op.length = q.len;
            next_q.op.addr = addr;
            next_q.op.row_words = (q.opcode == `FPC_OP_PROG_CODE_ROW
               || q.opcode == `FPC_OP_ERASE_CODE_ROWS || q.opcode == `FPC_OP_READ_CODE)
               ? `FPC_CODE_ROW_WORDS : `FPC_EE_ROW_WORDS;
            next_q.op.keep_unit_id = (q.opcode == `FPC_OP_BULK_ERASE);
            next_q.op.clear_unit_id = (q.opcode == `FPC_OP_ERASE_CODE_ROWS)
               && (addr[23:6] == `FPC_UID_LO >> 6);
            if (cmd_ok) begin
               next_q.csum = 16'h0000;
            end
            next_q.st = S_BUSY;
         end
         S_BUSY: begin
            // a refused command still shows one busy cycle before its answer
            if (!q.ok) begin
               next_q.st = S_READY;
            end else if (OP_DONE) begin
               next_q.ok = OP_DONE_OK;
               next_q.st = S_READY;
            end else if (q.timer == limit(q.opcode) - 24'h000001) begin
               next_q.ok = 1'b0;
               next_q.st = S_READY;
            end else begin
               next_q.timer = q.timer + 24'h000001;
            end
            next_q.pulse = 10'h000;
         end
         S_READY: begin
            next_q.pulse = q.pulse + 10'h001;
            if (q.pulse == READY_LAST) begin
               next_q.pulse = 10'h000;
               next_q.word_sel = 1'b0;
               next_q.st = S_SEND;
            end
         end
         S_SEND: begin
            if (tx_done) begin
               next_q.word_sel = 1'b1;
               if (q.word_sel) begin
                  next_q.st = S_IDLE;
               end
            end
         end
      endcase
   end

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         q <= '0;
         q.st <= S_IDLE;
      end else begin
         q <= next_q;
      end
   end

   // line released while the programmer talks; high while busy, low for the ready pulse
   always_comb begin
      PROG_SERIAL_DATA_PIN_OE_N = 1'b1;
      PROG_SERIAL_DATA_PIN_OUT = 1'b1;
      unique case (q.st)
         S_BUSY: begin
            PROG_SERIAL_DATA_PIN_OE_N = 1'b0;
            PROG_SERIAL_DATA_PIN_OUT = 1'b1;
         end
         S_READY: begin
            PROG_SERIAL_DATA_PIN_OE_N = 1'b0;
            PROG_SERIAL_DATA_PIN_OUT = 1'b0;
         end
         S_SEND: begin
            PROG_SERIAL_DATA_PIN_OE_N = 1'b0;
            PROG_SERIAL_DATA_PIN_OUT = tx_bit;
         end
         default: begin
            PROG_SERIAL_DATA_PIN_OE_N = 1'b1;
            PROG_SERIAL_DATA_PIN_OUT = 1'b1;
         end
      endcase
   end

   assign OP_START = q.op_start;
   assign OP = q.op;
   assign DATA_WORD = q.rd_word;
   assign CHECKSUM = q.csum;

   busy_high_a: assert property (@(posedge CLK) disable iff (RST)
      $rose(q.st == S_BUSY) |-> !PROG_SERIAL_DATA_PIN_OE_N && PROG_SERIAL_DATA_PIN_OUT)
      else $error("line not held high while busy");

   ready_low_a: assert property (@(posedge CLK) disable iff (RST)
      $rose(q.st == S_READY) |-> (!PROG_SERIAL_DATA_PIN_OE_N && !PROG_SERIAL_DATA_PIN_OUT)[*8])
      else $error("ready pulse not driven low");

   ready_width_a: assert property (@(posedge CLK) disable iff (RST)
      $rose(q.st == S_SEND) |-> $past(q.pulse) == READY_LAST && $past(q.st) == S_READY)
      else $error("ready pulse width wrong");

   line_free_a: assert property (@(posedge CLK) disable iff (RST)
      (q.st == S_IDLE || q.st == S_RECV) |-> PROG_SERIAL_DATA_PIN_OE_N)
      else $error("line driven while command arrives");

   one_answer_a: assert property (@(posedge CLK) disable iff (RST)
      OP_START |-> $past(q.st) == S_CHECK ##1 !OP_START)
      else $error("operation started outside command check");

   code_row_ack_a: assert property (@(posedge CLK) disable iff (RST)
      tx_load && q.st == S_READY && q.ok && q.opcode == `FPC_OP_PROG_CODE_ROW
      |-> tx_word == 16'h1500)
      else $error("code row ack word wrong");

   resp_second_a: assert property (@(posedge CLK) disable iff (RST)
      tx_load && q.st == S_SEND |-> tx_word == 16'h0002 && !q.word_sel)
      else $error("second response word wrong");

   reserved_nack_a: assert property (@(posedge CLK) disable iff (RST)
      q.st == S_CHECK && q.opcode == `FPC_OP_RESERVED |=> !q.ok && !OP_START)
      else $error("reserved opcode accepted");

   config_range_a: assert property (@(posedge CLK) disable iff (RST)
      q.st == S_CHECK && q.opcode == `FPC_OP_PROG_CONFIG && addr > `FPC_CFG_HI |=> !q.ok)
      else $error("configuration write outside range accepted");

   busy_bound_a: assert property (@(posedge CLK) disable iff (RST)
      q.st == S_BUSY |-> q.timer < limit(q.opcode))
      else $error("busy wait overran its timeout");

   unit_id_a: assert property (@(posedge CLK) disable iff (RST)
      OP_START && OP.opcode == `FPC_OP_BULK_ERASE |-> OP.keep_unit_id && !OP.clear_unit_id)
      else $error("bulk erase does not keep unit id");

   answer_done_a: assert property (@(posedge CLK) disable iff (RST)
      q.st == S_SEND && tx_done && q.word_sel |=> q.st == S_IDLE && PROG_SERIAL_DATA_PIN_OE_N)
      else $error("line not released after second response word");

   busy_timeout_a: assert property (@(posedge CLK) disable iff (RST)
      q.st == S_BUSY && q.ok && !OP_DONE && q.timer == limit(q.opcode) - 24'h000001
      |=> q.st == S_READY && !q.ok)
      else $error("timeout does not end busy with nack");

   length_check_a: assert property (@(posedge CLK) disable iff (RST)
      q.st == S_CHECK && q.len != cmd_len(q.opcode) |=> !q.ok && !OP_START)
      else $error("command of wrong length accepted");

   code_row_go_a: assert property (@(posedge CLK) disable iff (RST)
      q.st == S_CHECK && q.opcode == `FPC_OP_PROG_CODE_ROW && q.len == `FPC_LEN_PROG_CODE_ROW
      |=> q.ok && OP_START && OP.row_words == `FPC_CODE_ROW_WORDS)
      else $error("code row program not started");

   config_sum_a: assert property (@(posedge CLK) disable iff (RST)
      CSUM_IN.valid && !CSUM_IN.is_code && q.st != S_CHECK |=> CHECKSUM - $past(CHECKSUM)
      == $past(16'(CSUM_IN.word[15:8])) + $past(16'(CSUM_IN.word[7:0])))
      else $error("configuration word not summed by its low two bytes");

   ready_hold_a: assert property (@(posedge CLK) disable iff (RST)
      q.st == S_READY && q.pulse != READY_LAST
      |=> q.st == S_READY && q.pulse == $past(q.pulse) + 10'h001)
      else $error("ready pulse cut short");

   unit_id_clear_a: assert property (@(posedge CLK) disable iff (RST)
      OP_START && OP.opcode == `FPC_OP_ERASE_CODE_ROWS && OP.addr == `FPC_UID_LO
      |-> OP.clear_unit_id && !OP.keep_unit_id)
      else $error("row erase of unit id row does not clear it");
endmodule // fpc_core

// [bench/fpc_prog_model.sv]
`timescale 1ns/1ps
module fpc_prog_model (
   output logic prog_serial_clock_pin,
   output logic pgd_drv,
   output logic pgd_oe,
   input wire logic prog_serial_data_pin
);
   // link clock stands low outside frames; one command at a time from here only
   initial begin
      prog_serial_clock_pin = 1'b0;
      pgd_drv = 1'b0;
      pgd_oe = 1'b0;
   end

   task automatic send_words(input logic [50:0][15:0] w, input int n);
      for (int k = 0; k < n; k++) begin
         for (int i = 15; i >= 0; i--) begin
            pgd_oe = 1'b1;
            pgd_drv = w[k][i];
            #100 prog_serial_clock_pin = 1'b1;
            #100 prog_serial_clock_pin = 1'b0;
         end
      end
      pgd_oe = 1'b0;
   endtask

   // sampled late in the high phase: the device shifts after its input filter delay
   task automatic recv_word(output logic [15:0] w);
      for (int i = 15; i >= 0; i--) begin
         #100 prog_serial_clock_pin = 1'b1;
         #95 w[i] = prog_serial_data_pin;
         #5 prog_serial_clock_pin = 1'b0;
      end
   endtask
endmodule // fpc_prog_model

// [bench/fpc_core_bench.sv]
`timescale 1ns/1ps
module fpc_core_bench;
   import fpc_pkg::*;
   localparam logic [3:0] OPS [11] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9,
      4'ha, 4'hb};
   localparam logic [7:0] LENS [11] = '{8'h01, 8'h04, 8'h04, 8'h13, 8'h33, 8'h04, 8'h02, 8'h03,
      8'h03, 8'h03, 8'h01};
   logic clk, rst, prog_serial_clock_pin, p_drv, p_oe, prog_serial_data_pin, dout, oe_n, op_start, op_done, op_done_ok;
   fpc_op_t op;
   logic [5:0] data_index;
   logic [15:0] data_word, checksum;
   fpc_csum_in_t csum_in;
   int err_count, cmp_count, starts;

   // released line shows the inverse of the last bit, not a held value
   assign prog_serial_data_pin = !oe_n ? dout : (p_oe ? p_drv : ~p_drv);

   fpc_core #(.T_1MS_CYC(24'd200), .T_5MS_CYC(24'd400), .T_300MS_CYC(24'd800)) i_fpc_core (
      .CLK(clk), .RST(rst), .PROG_SERIAL_CLOCK_PIN(prog_serial_clock_pin), .PROG_SERIAL_DATA_PIN_IN(prog_serial_data_pin),
      .PROG_SERIAL_DATA_PIN_OUT(dout), .PROG_SERIAL_DATA_PIN_OE_N(oe_n), .OP_START(op_start),
      .OP(op), .OP_DONE(op_done), .OP_DONE_OK(op_done_ok), .DATA_INDEX(data_index),
      .DATA_WORD(data_word), .CSUM_IN(csum_in), .CHECKSUM(checksum));
   fpc_prog_model i_fpc_prog_model (.prog_serial_clock_pin(prog_serial_clock_pin), .pgd_drv(p_drv), .pgd_oe(p_oe), .prog_serial_data_pin(prog_serial_data_pin));

   always #12.5 clk = ~clk;
   always @(posedge clk) if (op_start === 1'b1) starts++;

   task automatic stop_test;
      $display("comparisons %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         err_count++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic tick;
      @(posedge clk);
      #1;
   endtask

   // done_at 0 leaves the backend silent so the device must time out
   task automatic run_cmd(input logic [3:0] opc, input logic [7:0] len, input logic [23:0] addr,
         input int done_at, input logic ok, input logic [15:0] exp0, output int busy);
      logic [50:0][15:0] w;
      logic [15:0] r;
      int n;
      for (int i = 0; i < 51; i++) w[i] = 16'h1357 + 16'(i);
      w[0] = {opc, 4'h0, len};
      w[1] = {8'h00, addr[23:16]};
      w[2] = addr[15:0];
      i_fpc_prog_model.send_words(w, int'(len));
      n = 0;
      while (!(oe_n === 1'b0 && dout === 1'b1) && n < 200) begin
         tick();
         n++;
      end
      if (n >= 200) begin
         err_count++;
         stop_test();
      end
      busy = 0;
      while (dout === 1'b1 && busy < 1000) begin
         tick();
         busy++;
         op_done = (busy == done_at);
         op_done_ok = ok;
      end
      op_done = 1'b0;
      if (busy >= 1000) begin
         err_count++;
         stop_test();
      end
      // the first answer bit is low as well, so only the full low stretch shows on the pin
      n = 0;
      while (dout === 1'b0 && n < 600) begin
         tick();
         n++;
      end
      check(24'(n), 24'd600);
      i_fpc_prog_model.recv_word(r);
      check(r, exp0);
      i_fpc_prog_model.recv_word(r);
      check(r, 16'h0002);
      repeat (8) tick();
      check(oe_n, 1'b1);
   endtask

   task automatic t_reset;
      check({oe_n, op_start}, 2'b10);
      check({checksum, data_word}, 32'h00000000);
   endtask

   task automatic t_all_ops;
      int s, b;
      for (int i = 0; i < 11; i++) begin
         s = starts;
         run_cmd(OPS[i], LENS[i], 24'hf80000, 5, 1'b1, {4'h1, OPS[i], 8'h00}, b);
         check(24'(starts - s), 24'd1);
         check({op.opcode, op.length}, {OPS[i], LENS[i]});
      end
   endtask

   task automatic t_refuse;
      int s, b;
      s = starts;
      run_cmd(4'h3, 8'h01, 24'h0, 5, 1'b1, 16'h2300, b);
      run_cmd(4'h0, 8'h02, 24'h0, 5, 1'b1, 16'h2000, b);
      run_cmd(4'hc, 8'h01, 24'h0, 5, 1'b1, 16'h2c00, b);
      run_cmd(4'h6, 8'h04, 24'hf8000e, 5, 1'b1, 16'h2600, b);
      check(24'(starts - s), 24'd0);
      run_cmd(4'h6, 8'h04, 24'hf8000c, 5, 1'b0, 16'h2600, b);
      check(24'(starts - s), 24'd1);
   endtask

   task automatic t_code_row;
      int b;
      run_cmd(4'h4, 8'h13, 24'h000100, 3, 1'b1, 16'h1400, b);
      check(op.row_words, 6'h10);
      run_cmd(4'h5, 8'h33, 24'h001240, 7, 1'b1, 16'h1500, b);
      check({op.addr, 2'b00, op.row_words}, {24'h001240, 8'h20});
      data_index = 6'd3;
      repeat (2) tick();
      check(data_word, 16'h135a);
   endtask

   task automatic t_unit_id;
      int b;
      run_cmd(4'h9, 8'h03, 24'h8005c0, 4, 1'b1, 16'h1900, b);
      check(op.clear_unit_id, 1'b1);
      run_cmd(4'h7, 8'h02, 24'h000000, 4, 1'b1, 16'h1700, b);
      check({op.keep_unit_id, op.clear_unit_id}, 2'b10);
   endtask

   task automatic t_timeout;
      int b;
      run_cmd(4'hb, 8'h01, 24'h0, 0, 1'b1, 16'h2b00, b);
      check(24'(b > 190 && b < 215), 24'd1);
   endtask

   task automatic t_checksum;
      int b;
      csum_in = '{valid: 1'b1, is_code: 1'b1, word: 24'h123456};
      tick();
      csum_in = '{valid: 1'b1, is_code: 1'b0, word: 24'hff1234};
      tick();
      csum_in = '0;
      tick();
      check(checksum, 16'h00e2);
      run_cmd(4'h0, 8'h01, 24'h0, 2, 1'b1, 16'h1000, b);
      check(checksum, 16'h0000);
   endtask

   initial begin
      clk = 1'b0;
      rst = 1'b1;
      op_done = 1'b0;
      op_done_ok = 1'b0;
      data_index = 6'd0;
      csum_in = '0;
      err_count = 0;
      cmp_count = 0;
      repeat (5) @(posedge clk);
      #1 rst = 1'b0;
      repeat (4) tick();
      t_reset();
      t_all_ops();
      t_refuse();
      t_code_row();
      t_unit_id();
      t_timeout();
      t_checksum();
      stop_test();
   end
endmodule // fpc_core_bench
